// *** design/dpll_ref_cfg.svh ***
// Offsets, field positions and reset values of the reference switch block
`ifndef DPLL_REF_CFG_SVH
`define DPLL_REF_CFG_SVH

`define REF_NUM         4
`define PRIO_W          3
`define FAIL_W          4
`define ADDR_W          8
`define DATA_W          8
`define PRIO_NONE       3'h7

`define OFS_SW_MASK     8'h01
`define OFS_HO_MASK     8'h02
`define OFS_FAIL_SUM    8'h05
`define OFS_CTRL_BASE   8'h10
`define OFS_STAT_BASE   8'h20
`define OFS_PRIO_BASE   8'h30

`define RST_SW_MASK     4'h8
`define RST_HO_MASK     4'h7
`define RST_PRIO        12'h688
`define RST_CTRL        8'h00

`define CTL_STATE_LSB   0
`define CTL_SEL_LSB     2
`define CTL_MANAGED_BIT 4
`define CTL_HITLESS_BIT 5

`define REQ_NORMAL      2'h0
`define REQ_HOLDOVER    2'h1
`define REQ_FREERUN     2'h2

`define PRIO_LO_LSB     0
`define PRIO_HI_LSB     4

`endif

// *** design/dpll_ref_pkg.sv ***
// Types shared by the reference switch block
`default_nettype none
package dpll_ref_pkg;
	typedef enum logic [1:0] {ST_FREERUN, ST_NORMAL, ST_HOLDOVER} dpll_state_t;
	typedef logic [2:0] prio_t;
	typedef logic [1:0] ref_idx_t;
endpackage
`default_nettype wire

// *** design/ref_pick_if.sv ***
// Carrier between the selection machine and its priority picker
`default_nettype none
interface ref_pick_if;
	import dpll_ref_pkg::*;
	prio_t    [3:0] prio;
	logic     [3:0] qual;
	ref_idx_t       best;
	logic           best_valid;
	modport picker (input prio, input qual, output best, output best_valid);
	modport user   (output prio, output qual, input best, input best_valid);
endinterface
`default_nettype wire

// *** design/ref_picker.sv ***
// Picks the qualified reference with the best priority
`default_nettype none
module ref_picker
	import dpll_ref_pkg::*;
(
	ref_pick_if.picker p
);
	always_comb
	begin
		p.best       = 2'h0;
		p.best_valid = 1'b0;
		// Strict compare keeps the lower index on a tie
		for (int r = 0; r < 4; r++)
		begin
			if (p.qual[r] && (!p.best_valid || (p.prio[r] < p.prio[p.best])))
			begin
				p.best       = r[1:0];
				p.best_valid = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** design/dpll_reference_switch_fsm.sv ***
// State control and reference selection machines for all DPLLs
`include "dpll_ref_cfg.svh"
`default_nettype none
module dpll_reference_switch_fsm
	import dpll_ref_pkg::*;
#(
	parameter int NUM_DPLL = 2
)
(
	input  wire logic                             clk_i,
	input  wire logic                             nrst_i,
	input  wire logic [`ADDR_W-1:0]               addr_i,
	input  wire logic [`DATA_W-1:0]               wdata_i,
	input  wire logic                             wr_i,
	input  wire logic                             rd_i,
	output logic      [`DATA_W-1:0]               rdata_o,
	input  wire logic [`REF_NUM-1:0]              signal_absent_fail_i,
	input  wire logic [`REF_NUM-1:0]              single_cycle_monitor_fail_i,
	input  wire logic [`REF_NUM-1:0]              coarse_freq_monitor_fail_i,
	input  wire logic [`REF_NUM-1:0]              guard_soak_fail_i,
	input  wire logic [NUM_DPLL-1:0]              dpll_lock_i,
	output logic      [NUM_DPLL-1:0][1:0]         ref_status_o,
	output logic      [NUM_DPLL-1:0]              normal_o,
	output logic      [NUM_DPLL-1:0]              holdover_o,
	output logic      [NUM_DPLL-1:0]              freerun_o,
	output logic      [NUM_DPLL-1:0]              auto_holdover_o,
	output logic      [NUM_DPLL-1:0]              lock_o,
	output logic      [NUM_DPLL-1:0][2:0]         ref_monitor_o,
	output logic      [NUM_DPLL-1:0][1:0]         state_ctl_o,
	output logic      [NUM_DPLL-1:0][1:0]         ref_sel_ctl_o,
	output logic      [NUM_DPLL-1:0]              hitless_o
);
	localparam int NR = `REF_NUM;

	typedef struct packed {
		logic        [`FAIL_W-1:0]            sw_mask;
		logic        [`FAIL_W-1:0]            ho_mask;
		logic        [NUM_DPLL-1:0][NR-1:0][`PRIO_W-1:0] prio;
		logic        [NUM_DPLL-1:0][`DATA_W-1:0] ctrl;
		dpll_state_t [NUM_DPLL-1:0]           st;
		logic        [NUM_DPLL-1:0][1:0]      ref_sel;
		logic        [NUM_DPLL-1:0]           auto_ho;
		logic        [NUM_DPLL-1:0][1:0]      ref_status;
		logic        [NUM_DPLL-1:0]           normal;
		logic        [NUM_DPLL-1:0]           holdover;
		logic        [NUM_DPLL-1:0]           freerun;
		logic        [NUM_DPLL-1:0]           lock;
		logic        [NUM_DPLL-1:0][2:0]      mon;
		logic        [NUM_DPLL-1:0][1:0]      state_ctl;
		logic        [NUM_DPLL-1:0][1:0]      sel_ctl;
		logic        [NUM_DPLL-1:0]           hitless;
		logic        [`DATA_W-1:0]            rdata;
	} state_t;

	state_t q;
	state_t n;

	logic [NR-1:0][`FAIL_W-1:0]   fail_vec;
	logic [NR-1:0]                sw_fail;
	logic [NR-1:0]                ho_fail;
	logic [NUM_DPLL-1:0][NR-1:0]  qual;
	logic [NUM_DPLL-1:0][1:0]     best_w;
	logic [NUM_DPLL-1:0]          best_valid_w;

	// Failure vector bit order: absent, single cycle, coarse freq, guard soak
	genvar gr;
	generate
		for (gr = 0; gr < NR; gr++)
		begin : g_ref
			assign fail_vec[gr] = {guard_soak_fail_i[gr], coarse_freq_monitor_fail_i[gr],
				single_cycle_monitor_fail_i[gr], signal_absent_fail_i[gr]};
			assign sw_fail[gr]  = |(fail_vec[gr] & q.sw_mask);
			assign ho_fail[gr]  = |(fail_vec[gr] & q.ho_mask);
		end
	endgenerate

	ref_pick_if pick_if[NUM_DPLL] ();

	genvar gd;
	generate
		for (gd = 0; gd < NUM_DPLL; gd++)
		begin : g_dpll
			for (genvar r = 0; r < NR; r++)
			begin : g_qual
				assign qual[gd][r] = !sw_fail[r] && !ho_fail[r]
					&& (q.prio[gd][r] != `PRIO_NONE);
			end
			assign pick_if[gd].prio  = q.prio[gd];
			assign pick_if[gd].qual  = qual[gd];
			assign best_w[gd]        = pick_if[gd].best;
			assign best_valid_w[gd]  = pick_if[gd].best_valid;
			ref_picker u_picker
			(
				.p (pick_if[gd])
			);
		end
	endgenerate

	always_comb
	begin
		logic [1:0] cur;
		logic [1:0] sel;
		logic [1:0] req;
		logic [1:0] bst;
		logic [`ADDR_W-1:0] a_ctrl;
		logic [`ADDR_W-1:0] a_stat;
		logic [`ADDR_W-1:0] a_prio;
		logic               mgd;
		logic               sw_cond;
		logic               better;
		mgd     = 1'b0;
		sw_cond = 1'b0;
		better  = 1'b0;
		cur    = 2'h0;
		sel    = 2'h0;
		req    = 2'h0;
		bst    = 2'h0;
		a_ctrl = '0;
		a_stat = '0;
		a_prio = '0;
		n      = q;
		n.rdata = '0;

		// Register writes
		if (wr_i)
		begin
			case (addr_i)
				`OFS_SW_MASK: n.sw_mask = wdata_i[`FAIL_W-1:0];
				`OFS_HO_MASK: n.ho_mask = wdata_i[`FAIL_W-1:0];
				default: ;
			endcase
		end

		// Register reads; unmapped addresses return zero
		if (rd_i)
		begin
			case (addr_i)
				`OFS_SW_MASK:  n.rdata = {4'h0, q.sw_mask};
				`OFS_HO_MASK:  n.rdata = {4'h0, q.ho_mask};
				`OFS_FAIL_SUM: n.rdata = {ho_fail, sw_fail};
				default: ;
			endcase
		end

		for (int d = 0; d < NUM_DPLL; d++)
		begin
			a_ctrl = `OFS_CTRL_BASE + 8'(d);
			a_stat = `OFS_STAT_BASE + 8'(d);
			a_prio = `OFS_PRIO_BASE + 8'(2 * d);
			if (wr_i && (addr_i == a_ctrl))
				n.ctrl[d] = wdata_i;
			if (wr_i && (addr_i == a_prio))
			begin
				n.prio[d][0] = wdata_i[`PRIO_LO_LSB +: `PRIO_W];
				n.prio[d][1] = wdata_i[`PRIO_HI_LSB +: `PRIO_W];
			end
			if (wr_i && (addr_i == (a_prio + 8'h01)))
			begin
				n.prio[d][2] = wdata_i[`PRIO_LO_LSB +: `PRIO_W];
				n.prio[d][3] = wdata_i[`PRIO_HI_LSB +: `PRIO_W];
			end
			if (rd_i && (addr_i == a_ctrl))
				n.rdata = q.ctrl[d];
			if (rd_i && (addr_i == a_stat))
				n.rdata = {1'b0, q.auto_ho[d], q.lock[d], q.freerun[d],
					q.holdover[d], q.normal[d], q.ref_sel[d]};
			if (rd_i && (addr_i == a_prio))
				n.rdata = {1'b0, q.prio[d][1], 1'b0, q.prio[d][0]};
			if (rd_i && (addr_i == (a_prio + 8'h01)))
				n.rdata = {1'b0, q.prio[d][3], 1'b0, q.prio[d][2]};

			// Decision uses registered controls, so it lags a write by one cycle
			cur = q.ref_sel[d];
			sel = q.ctrl[d][`CTL_SEL_LSB +: 2];
			req = q.ctrl[d][`CTL_STATE_LSB +: 2];
			bst = best_w[d];
			mgd     = q.ctrl[d][`CTL_MANAGED_BIT];
			// Excluded current reference counts as failed, so it is left at once for the best qualified one, or held in holdover if none
			sw_cond = sw_fail[cur] || (q.prio[d][cur] == `PRIO_NONE);
			better  = best_valid_w[d] && (q.prio[d][bst] < q.prio[d][cur]);
			if (mgd)
			begin
				if (sel != cur)
				begin
					// New selection always rests one cycle in holdover first
					n.ref_sel[d] = sel;
					n.st[d]      = ST_HOLDOVER;
					n.auto_ho[d] = 1'b1;
				end
				else
				begin
					case (req)
						`REQ_HOLDOVER:
						begin
							n.st[d]      = ST_HOLDOVER;
							n.auto_ho[d] = 1'b0;
						end
						`REQ_FREERUN:
						begin
							n.st[d]      = ST_FREERUN;
							n.auto_ho[d] = 1'b0;
						end
						default:
						begin
							// Reference stays put whichever way holdover goes
							if (ho_fail[cur])
							begin
								n.st[d]      = ST_HOLDOVER;
								n.auto_ho[d] = 1'b1;
							end
							else
							begin
								n.st[d]      = ST_NORMAL;
								n.auto_ho[d] = 1'b0;
							end
						end
					endcase
				end
			end
			else
			begin
				// Starts from whatever ref_sel holds, managed or not before
				if (q.st[d] == ST_FREERUN)
				begin
					if (best_valid_w[d])
					begin
						n.ref_sel[d] = bst;
						n.st[d]      = ST_NORMAL;
					end
					n.auto_ho[d] = 1'b0;
				end
				else if (sw_cond)
				begin
					if (best_valid_w[d])
					begin
						n.ref_sel[d] = bst;
						n.st[d]      = ST_NORMAL;
						n.auto_ho[d] = 1'b0;
					end
					else
					begin
						n.st[d]      = ST_HOLDOVER;
						n.auto_ho[d] = 1'b1;
					end
				end
				else if (better)
				begin
					n.ref_sel[d] = bst;
					n.st[d]      = ST_NORMAL;
					n.auto_ho[d] = 1'b0;
				end
				else if (ho_fail[cur])
				begin
					n.st[d]      = ST_HOLDOVER;
					n.auto_ho[d] = 1'b1;
				end
				else
				begin
					n.st[d]      = ST_NORMAL;
					n.auto_ho[d] = 1'b0;
				end
			end

			// Outputs registered from next state so they match the state flops
			n.ref_status[d] = n.ref_sel[d];
			n.normal[d]     = (n.st[d] == ST_NORMAL);
			n.holdover[d]   = (n.st[d] == ST_HOLDOVER);
			n.freerun[d]    = (n.st[d] == ST_FREERUN);
			n.lock[d]       = dpll_lock_i[d] && (n.st[d] == ST_NORMAL);
			n.mon[d]        = fail_vec[n.ref_sel[d]][2:0];
			n.state_ctl[d]  = n.ctrl[d][`CTL_STATE_LSB +: 2];
			n.sel_ctl[d]    = n.ctrl[d][`CTL_SEL_LSB +: 2];
			n.hitless[d]    = n.ctrl[d][`CTL_HITLESS_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			q.sw_mask <= `RST_SW_MASK;
			q.ho_mask <= `RST_HO_MASK;
			q.rdata   <= '0;
			// Field by field, so no flop is assigned twice in one branch
			for (int d = 0; d < NUM_DPLL; d++)
			begin
				q.prio[d]       <= `RST_PRIO;
				q.ctrl[d]       <= `RST_CTRL;
				q.st[d]         <= ST_FREERUN;
				q.ref_sel[d]    <= '0;
				q.auto_ho[d]    <= 1'b0;
				q.ref_status[d] <= '0;
				q.normal[d]     <= 1'b0;
				q.holdover[d]   <= 1'b0;
				q.freerun[d]    <= 1'b1;
				q.lock[d]       <= 1'b0;
				q.mon[d]        <= '0;
				q.state_ctl[d]  <= '0;
				q.sel_ctl[d]    <= '0;
				q.hitless[d]    <= 1'b0;
			end
		end
		else
		begin
			q <= n;
		end
	end

	assign rdata_o         = q.rdata;
	assign ref_status_o    = q.ref_status;
	assign normal_o        = q.normal;
	assign holdover_o      = q.holdover;
	assign freerun_o       = q.freerun;
	assign auto_holdover_o = q.auto_ho;
	assign lock_o          = q.lock;
	assign ref_monitor_o   = q.mon;
	assign state_ctl_o     = q.state_ctl;
	assign ref_sel_ctl_o   = q.sel_ctl;
	assign hitless_o       = q.hitless;
endmodule
`default_nettype wire

// *** tb/ref_mon_model.sv ***
// Model of the reference monitors and the DPLL cores feeding the block
`default_nettype none
module ref_mon_model
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic [15:0] req_i,
	output logic      [3:0]  absent_o,
	output logic      [3:0]  single_o,
	output logic      [3:0]  coarse_o,
	output logic      [3:0]  soak_o,
	output logic      [1:0]  lock_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Monitors flag a failure one clock after the bench asks for it
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			{soak_o, coarse_o, single_o, absent_o} <= 16'h0000;
			lock_o <= 2'h0;
		end
		else
		begin
			{soak_o, coarse_o, single_o, absent_o} <= req_i;
			lock_o <= 2'h3;
		end
	end
endmodule
`default_nettype wire

// *** tb/dpll_ref_sva.sv ***
// Port checker for the reference switch block
`default_nettype none
module dpll_ref_sva
#(
	parameter int NUM_DPLL = 2
)
(
	input wire logic                     clk_i,
	input wire logic                     nrst_i,
	input wire logic                     wr_i,
	input wire logic                     rd_i,
	input wire logic [7:0]               rdata_o,
	input wire logic [3:0]               signal_absent_fail_i,
	input wire logic [3:0]               single_cycle_monitor_fail_i,
	input wire logic [3:0]               coarse_freq_monitor_fail_i,
	input wire logic [NUM_DPLL-1:0]      dpll_lock_i,
	input wire logic [NUM_DPLL-1:0][1:0] ref_status_o,
	input wire logic [NUM_DPLL-1:0]      normal_o,
	input wire logic [NUM_DPLL-1:0]      holdover_o,
	input wire logic [NUM_DPLL-1:0]      freerun_o,
	input wire logic [NUM_DPLL-1:0]      auto_holdover_o,
	input wire logic [NUM_DPLL-1:0]      lock_o,
	input wire logic [NUM_DPLL-1:0][2:0] ref_monitor_o,
	input wire logic [NUM_DPLL-1:0][1:0] state_ctl_o,
	input wire logic [NUM_DPLL-1:0][1:0] ref_sel_ctl_o,
	input wire logic [NUM_DPLL-1:0]      hitless_o
);
	logic [3:0] ab_q;
	logic [3:0] sc_q;
	logic [3:0] cf_q;
	// Copies of the absent, single cycle and coarse freq monitors, since the used ref is only known afterwards
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			{ab_q, sc_q, cf_q} <= 12'h000;
		else
			{ab_q, sc_q, cf_q} <= {signal_absent_fail_i, single_cycle_monitor_fail_i,
				coarse_freq_monitor_fail_i};
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	state_hot_a: assert property ($onehot({normal_o[0], holdover_o[0], freerun_o[0]}))
		else $error("dpll0 state not one-hot");
	state_hot1_a: assert property ($onehot({normal_o[1], holdover_o[1], freerun_o[1]}))
		else $error("dpll1 state not one-hot");
	lock_flag_a: assert property (lock_o[0] == ($past(dpll_lock_i[0]) && normal_o[0]))
		else $error("lock flag wrong");
	auto_ho_a: assert property (auto_holdover_o[0] |-> holdover_o[0])
		else $error("auto holdover outside holdover");
	mon_bits_a: assert property (ref_monitor_o[0] == {cf_q[ref_status_o[0]],
		sc_q[ref_status_o[0]], ab_q[ref_status_o[0]]})
		else $error("monitor bits wrong");
	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read");
	ctl_hold_a: assert property (!$past(wr_i) && !$past(wr_i, 2) |->
		$stable(state_ctl_o[0]) && $stable(ref_sel_ctl_o[0]))
		else $error("control copy changed without write");
	hitless_hold_a: assert property (!$past(wr_i) && !$past(wr_i, 2) |-> $stable(hitless_o[0]))
		else $error("hitless copy changed without write");
	ho_ref_a: assert property (holdover_o[0] && $past(holdover_o[0]) && !$past(wr_i)
		&& !$past(wr_i, 2) |-> $stable(ref_status_o[0]))
		else $error("reference moved in holdover");
	ho_seen_c: cover property (auto_holdover_o[0]);
	ref2_seen_c: cover property (normal_o[0] && ref_status_o[0] == 2'h2);
	lock_seen_c: cover property (lock_o[0] && ref_status_o[0] == 2'h1);
endmodule
bind dpll_reference_switch_fsm dpll_ref_sva #(.NUM_DPLL(NUM_DPLL)) sva_u (.clk_i, .nrst_i,
	.wr_i, .rd_i, .rdata_o, .signal_absent_fail_i, .single_cycle_monitor_fail_i,
	.coarse_freq_monitor_fail_i, .dpll_lock_i, .ref_status_o, .normal_o, .holdover_o,
	.freerun_o, .auto_holdover_o, .lock_o, .ref_monitor_o, .state_ctl_o, .ref_sel_ctl_o,
	.hitless_o);
`default_nettype wire

// *** tb/dpll_reference_switch_fsm_test.sv ***
// Self-checking bench for the reference switch block
`default_nettype none
module dpll_reference_switch_fsm_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  addr_i = 8'h00;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        rd_s = 1'b0;
	logic [15:0] req = 16'h0000;
	logic [3:0]  ab, sc, cf, gs;
	logic [1:0]  lk;
	logic [7:0]  rdata_o;
	logic [1:0][1:0] ref_status_o;
	logic [1:0][1:0] state_ctl_o;
	logic [1:0][1:0] ref_sel_ctl_o;
	logic [1:0]  normal_o, holdover_o, freerun_o, auto_holdover_o, lock_o, hitless_o;
	logic [1:0][7:0] ctl = '0;
	logic [7:0]  ra_s = 8'h00;
	logic [7:0]  pv;
	logic [7:0]  cv;
	logic [7:0]  pq[$];
	logic [7:0]  cq[$];
	logic [7:0]  rv;
	logic [7:0]  q[$];
	logic [31:0] seed = 32'hC77D;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          k;
	ref_mon_model mon_u (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .absent_o(ab),
		.single_o(sc), .coarse_o(cf), .soak_o(gs), .lock_o(lk));
	dpll_reference_switch_fsm #(.NUM_DPLL(2)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.signal_absent_fail_i(ab), .single_cycle_monitor_fail_i(sc),
		.coarse_freq_monitor_fail_i(cf), .guard_soak_fail_i(gs), .dpll_lock_i(lk),
		.ref_status_o(ref_status_o), .normal_o(normal_o), .holdover_o(holdover_o),
		.freerun_o(freerun_o), .auto_holdover_o(auto_holdover_o), .lock_o(lock_o),
		.ref_monitor_o(), .state_ctl_o(state_ctl_o), .ref_sel_ctl_o(ref_sel_ctl_o),
		.hitless_o(hitless_o));
	always #50 clk_i = ~clk_i;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic summarize();
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %0t pins got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		if (a[7:1] == 7'h08)
			ctl[a[0]] = d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		q.push_back(e);
		if (a[7:1] == 7'h10)
		begin
			pq.push_back(e);
			cq.push_back({3'h0, ctl[a[0]][5], ctl[a[0]][3:0]});
		end
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	// Status is read only after the write has landed and been decided on
	task automatic chk(input logic [7:0] e);
		repeat (3) @(posedge clk_i);
		rd(8'h20, e);
	endtask
	task automatic fl(input int kind, input logic [3:0] m);
		@(posedge clk_i);
		req[kind*4 +: 4] <= m;
		repeat (4) @(posedge clk_i);
	endtask
	// Read data stand one cycle, so the note is taken off in that cycle
	always @(posedge clk_i)
	begin
		rd_s <= rd_i;
		cyc <= cyc + 1;
		ra_s <= addr_i;
		if (rd_s)
			cmp(rdata_o, q.pop_front());
		// Pins are levels, so they are checked beside each status read
		if (rd_s && (ra_s[7:1] == 7'h10))
		begin
			pv = {1'b0, auto_holdover_o[ra_s[0]], lock_o[ra_s[0]], freerun_o[ra_s[0]],
				holdover_o[ra_s[0]], normal_o[ra_s[0]], ref_status_o[ra_s[0]]};
			cv = {3'h0, hitless_o[ra_s[0]], ref_sel_ctl_o[ra_s[0]], state_ctl_o[ra_s[0]]};
			cmp_pin(pv, pq.pop_front());
			cmp_pin(cv, cq.pop_front());
		end
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(8'h01, 8'h08);
		rd(8'h02, 8'h07);
		rd(8'h30, 8'h10);
		rd(8'h31, 8'h32);
		rd(8'h7E, 8'h00);
		rd(8'h20, 8'h24);
		rv = 8'(xs()) & 8'h0F;
		wr(8'h02, rv);
		rd(8'h02, rv);
		fl(3, 4'h1);
		chk(8'h25);
		fl(3, 4'h0);
		chk(8'h24);
		k = int'(xs() % 3);
		wr(8'h02, 8'h00);
		fl(k, 4'h1);
		chk(8'h24);
		wr(8'h02, 8'h07);
		chk(8'h48);
		fl(k, 4'h0);
		chk(8'h24);
		wr(8'h30, 8'h00);
		wr(8'h31, 8'h00);
		fl(3, 4'h1);
		chk(8'h25);
		fl(3, 4'h0);
		chk(8'h25);
		wr(8'h30, 8'h07);
		fl(3, 4'h2);
		chk(8'h26);
		fl(3, 4'hF);
		chk(8'h4A);
		fl(3, 4'h0);
		chk(8'h26);
		wr(8'h30, 8'h10);
		wr(8'h31, 8'h32);
		chk(8'h24);
		fl(0, 4'h4);
		wr(8'h10, 8'h18);
		chk(8'h4A);
		rd(8'h05, 8'h40);
		fl(0, 4'h0);
		chk(8'h26);
		wr(8'h10, 8'h34);
		chk(8'h25);
		rd(8'h10, 8'h34);
		wr(8'h10, 8'h15);
		chk(8'h09);
		wr(8'h10, 8'h14);
		wr(8'h30, 8'h00);
		wr(8'h31, 8'h00);
		wr(8'h10, 8'h04);
		chk(8'h25);
		rd(8'h21, 8'h24);
		repeat (3) @(posedge clk_i);
		summarize();
	end
endmodule
`default_nettype wire
